// [rtl/nxh_host.sv]
// Host controller that runs two-nibble transfers on the expander bus
module nxh_host
	import nxh_pkg::*;
#(
	parameter int NUM_CHIPS = 1
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic cmdValid,
	input wire nxh_cmd_s cmd,
	output logic cmdReady,
	output logic rspDone,
	output logic [3:0] rspData,
	output logic transferStrobe,
	output logic [NUM_CHIPS-1:0] chipSelN,
	input wire logic [3:0] nibbleBusIn,
	output logic [3:0] nibbleBusOut,
	output logic nibbleBusOe
);

	initial begin
		if (NUM_CHIPS < 1 || NUM_CHIPS > MAX_CHIPS) begin
			$error("nxh_host: NUM_CHIPS must be 1 to 4");
		end
		if (LOW_CYC > 15 || SETUP_CYC > 15 || HOLD_CYC > 15) begin
			$error("nxh_host: phase too long for the counter");
		end
	end

	////////////////////////////////////////////////////////////////////////
	// State and phase timing

	nxh_state_e state;
	nxh_state_e next_state;
	nxh_cmd_s cmdQ;
	logic discard;
	logic [15:0] lastWr;
	logic [3:0] busSync1;
	logic [3:0] busSync2;
	logic [CNT_W-1:0] count;
	logic [CNT_W-1:0] lastCount;
	logic phaseEnd;

	wire inIdle = (state == ST_IDLE);
	wire inSetup = (state == ST_SETUP);
	wire inLow = (state == ST_LOW);
	wire inHold = (state == ST_HOLD);
	wire accept = inIdle && cmdValid && cmdReady;
	wire isRead = (cmdQ.op == OP_READ);
	wire [3:0] slot = {cmdQ.chip, cmdQ.port};
	wire [3:0] cmdSlot = {cmd.chip, cmd.port};
	wire codePhase = inLow && (count < CNT_W'(CODE_HOLD_CYC));
	wire readSample = inLow && phaseEnd && isRead;
	wire frameEnd = inHold && phaseEnd;
	// First nibble: opcode high, port low
	wire [3:0] codeNibble = {cmdQ.op, cmdQ.port};

	// Phase length per state
	assign lastCount = inSetup ? CNT_W'(SETUP_CYC - 1) :
		inLow ? CNT_W'(LOW_CYC - 1) :
		inHold ? CNT_W'(HOLD_CYC - 1) : '0;

	nxh_phase_timer #(
		.W(CNT_W)
	) u_timer (
		.clk(clk),
		.nrst(nrst),
		.restart(accept || (phaseEnd && !inIdle)),
		.lastCount(lastCount),
		.count(count),
		.last(phaseEnd)
	);

	// Next state; a stale read is repeated at once
	always_comb begin
		next_state = state;
		case (state)
			ST_IDLE: begin
				if (accept) begin
					next_state = ST_SETUP;
				end
			end
			ST_SETUP: begin
				if (phaseEnd) begin
					next_state = ST_LOW;
				end
			end
			ST_LOW: begin
				if (phaseEnd) begin
					next_state = ST_HOLD;
				end
			end
			ST_HOLD: begin
				if (phaseEnd) begin
					next_state = discard ? ST_SETUP : ST_IDLE;
				end
			end
			default: begin
				next_state = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			state <= ST_IDLE;
		end else begin
			state <= next_state;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Command capture and stale-read tracking

	// A read of a port whose last access was a write is run twice; only the second counts
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			cmdQ <= '0;
			discard <= 1'b0;
		end else if (accept) begin
			cmdQ <= cmd;
			discard <= (cmd.op == OP_READ) && lastWr[cmdSlot];
		end else if (frameEnd) begin
			discard <= 1'b0;
		end
	end

	// One bit per chip and port: last access was a write
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			lastWr <= '0;
		end else if (frameEnd) begin
			lastWr[slot] <= !isRead;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Pins

	// Bus input comes from the expander, so it is synchronised first
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			busSync1 <= NIBBLE_RESET;
			busSync2 <= NIBBLE_RESET;
		end else begin
			busSync1 <= nibbleBusIn;
			busSync2 <= busSync1;
		end
	end

	// Write data replaces the code only after the code hold time
	wire [3:0] next_bus = (inLow && !codePhase) || inHold ?
		cmdQ.data : codeNibble;
	// Reads release the bus once the code is held long enough
	wire next_oe = inSetup || codePhase ||
		(!isRead && (inLow || inHold));
	wire next_strobe = !inLow;
	// One select line only, and only inside a frame
	wire [NUM_CHIPS-1:0] next_selN = inIdle ? '1 :
		~(NUM_CHIPS'(1) << cmdQ.chip);

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			transferStrobe <= STROBE_RESET;
			chipSelN <= '1;
			nibbleBusOut <= NIBBLE_RESET;
			nibbleBusOe <= 1'b0;
		end else begin
			transferStrobe <= next_strobe;
			chipSelN <= next_selN;
			nibbleBusOut <= next_bus;
			nibbleBusOe <= next_oe;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// User side answer

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			cmdReady <= 1'b0;
			rspDone <= 1'b0;
			rspData <= NIBBLE_RESET;
		end else begin
			cmdReady <= (next_state == ST_IDLE);
			rspDone <= frameEnd && !discard;
			if (readSample) begin
				rspData <= busSync2;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Checks

	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);

	sequence s_low_pulse;
		!transferStrobe [*8] ##1 !transferStrobe ##1 !transferStrobe
			##1 transferStrobe;
	endsequence

	sequence s_code_held;
		nibbleBusOe && $stable(nibbleBusOut);
	endsequence

	property p_two_nibbles;
		$fell(transferStrobe) |-> s_low_pulse;
	endproperty
	a_two_nibbles: assert property (p_two_nibbles)
		else $error("strobe low phase has the wrong length");

	property p_code_around_fall;
		$fell(transferStrobe) |->
			$past(nibbleBusOe) ##0 s_code_held ##0
			nibbleBusOut == {cmdQ.op, cmdQ.port};
	endproperty
	a_code_around_fall: assert property (p_code_around_fall)
		else $error("code nibble not held at strobe fall");

	property p_data_around_rise;
		$rose(transferStrobe) && cmdQ.op != OP_READ |->
			s_code_held ##0 nibbleBusOut == cmdQ.data ##1 s_code_held;
	endproperty
	a_data_around_rise: assert property (p_data_around_rise)
		else $error("write data not held around strobe rise");

	property p_one_select;
		$onehot0(~chipSelN) and
			($changed(transferStrobe) |-> !(&chipSelN));
	endproperty
	a_one_select: assert property (p_one_select)
		else $error("select lines wrong during a transfer");

	property p_stale_repeat;
		frameEnd && discard |=> inSetup && !rspDone;
	endproperty
	a_stale_repeat: assert property (p_stale_repeat)
		else $error("stale read was not repeated");

endmodule

// [rtl/nxh_phase_timer.sv]
// Phase counter that pulses on the last cycle of each timed phase
module nxh_phase_timer #(
	parameter int W = 4
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic restart,
	input wire logic [W-1:0] lastCount,
	output logic [W-1:0] count,
	output logic last
);

	initial begin
		if (W < 2) begin
			$error("nxh_phase_timer: W must be at least 2");
		end
	end

	// Last cycle of the phase
	assign last = (count == lastCount);

	// Counts up from zero after each restart
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			count <= '0;
		end else if (restart) begin
			count <= '0;
		end else begin
			count <= count + W'(1);
		end
	end

endmodule

// [rtl/nxh_pkg.sv]
// Constants, types and timing for the nibble expander host controller
// What this block does
// - Each transfer is two nibbles: opcode plus port, then four data bits.
// - Host holds code around the falling edge, write data around the rise.
// - Host discards the first read of a port after a write.
// - Host asserts exactly one expander's select line per transfer whose chip is below NUM_CHIPS, none otherwise.
package nxh_pkg;

	// Clock period of clk
	localparam int CLK_PERIOD_NS = 100;

	// Least times around the transfer strobe, in ns
	localparam int CODE_SETUP_NS = 100;
	localparam int CODE_HOLD_NS = 60;
	localparam int DATA_SETUP_NS = 200;
	localparam int DATA_HOLD_NS = 20;
	localparam int STROBE_LOW_NS = 700;
	localparam int SELECT_MARGIN_NS = 50;
	localparam int BUS_FLOAT_NS = 150;
	localparam int READ_ACCESS_NS = 650;

	localparam int SYNC_STAGES = 2;

	// Least time rounded up to whole cycles, never below one
	function automatic int cycUp(input int ns);
		int c;
		c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
		return (c < 1) ? 1 : c;
	endfunction

	function automatic int maxOf(input int a, input int b);
		return (a > b) ? a : b;
	endfunction

	localparam int CODE_HOLD_CYC = cycUp(CODE_HOLD_NS);
	localparam int SETUP_CYC =
		maxOf(cycUp(CODE_SETUP_NS), cycUp(SELECT_MARGIN_NS));
	// Read data is sampled through the synchroniser, hence the extra stages
	localparam int LOW_CYC = maxOf(cycUp(STROBE_LOW_NS),
		maxOf(CODE_HOLD_CYC + cycUp(DATA_SETUP_NS),
		cycUp(READ_ACCESS_NS) + SYNC_STAGES + 1));
	localparam int HOLD_CYC = maxOf(cycUp(DATA_HOLD_NS),
		maxOf(cycUp(SELECT_MARGIN_NS), cycUp(BUS_FLOAT_NS)));

	localparam int CNT_W = 4;
	localparam int MAX_CHIPS = 4;

	// Reset values of the pins
	localparam logic STROBE_RESET = 1'h1;
	localparam logic [3:0] NIBBLE_RESET = 4'h0;

	// Opcode in the high two bits of the first nibble
	typedef enum logic [1:0] {
		OP_READ = 2'h0,
		OP_DIRECT_PORT_WRITE = 2'h1,
		OP_OR_PORT_WRITE = 2'h2,
		OP_AND_PORT_WRITE = 2'h3
	} nxh_op_e;

	// Port address in the low two bits
	typedef enum logic [1:0] {
		PORT_A = 2'h0,
		PORT_B = 2'h1,
		PORT_C = 2'h2,
		PORT_D = 2'h3
	} nxh_port_e;

	typedef struct packed {
		nxh_op_e op;
		logic [1:0] chip;
		nxh_port_e port;
		logic [3:0] data;
	} nxh_cmd_s;

	typedef enum logic [3:0] {
		ST_IDLE = 4'h1,
		ST_SETUP = 4'h2,
		ST_LOW = 4'h4,
		ST_HOLD = 4'h8
	} nxh_state_e;

endpackage

// [verif/nxh_exp_model.sv]
// Behavioural expander: four latched ports behind the nibble bus
module nxh_exp_model
	import nxh_pkg::*;
(
	input wire logic strobe,
	input wire logic selN,
	input wire logic [3:0] bus,
	input wire logic [15:0] extPin,
	output logic [3:0] busOut,
	output logic busOe,
	output logic [15:0] latch,
	output logic [3:0] portOe
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [1:0] op;
	logic [1:0] port;
	logic [3:0] stale = 4'h0;
	logic [3:0] old;
	logic busy = 1'b0;
	////////////////////////////////////////
	// Power-up: ports float, bus is input, strobe level ignored
	initial begin
		busOe = 1'b0;
		busOut = 4'h0;
		latch = 16'h0000;
		portOe = 4'h0;
	end
	// Fall takes code and port; the first fall leaves power-on mode
	always @(negedge strobe) begin
		if (selN === 1'b0) begin
			{op, port} = bus;
			busy = 1'b1;
			if (op == 2'h0) begin
				portOe[port] = 1'b0;
				// Slow answer: nothing on the bus before the access time
				#(READ_ACCESS_NS);
				// Settling pins still show the latch on a first read
				busOut = stale[port] ? latch[port*4 +: 4] :
					extPin[port*4 +: 4];
				stale[port] = 1'b0;
				busOe = 1'b1;
			end
		end
	end
	// Rise: write result latched and driven, or the read ends
	always @(posedge strobe) begin
		if (busy && selN === 1'b0) begin
			old = latch[port*4 +: 4];
			case (op)
				2'h1: latch[port*4 +: 4] = bus;
				2'h2: latch[port*4 +: 4] = old | bus;
				2'h3: latch[port*4 +: 4] = old & bus;
				default: ;
			endcase
			portOe[port] = (op != 2'h0);
			stale[port] = (op != 2'h0);
			busOe = 1'b0;
		end
		busy = 1'b0;
	end
endmodule

// [verif/tb.sv]
// Testbench: host controller against the behavioural expander
module tb
	import nxh_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic cmdValid = 1'b0;
	nxh_cmd_s cmd = '0;
	logic cmdReady, rspDone, transferStrobe, busOe, devOe;
	logic [3:0] rspData, busOut, devOut, portOe;
	logic [3:0] lastBus = 4'h0;
	logic [1:0] chipSelN;
	logic [15:0] latch;
	logic [15:0] extPin = 16'h0000;
	wire [3:0] busWire;
	int n_fail = 0;
	int compares = 0;
	int cycles = 0;
	always #50 clk = ~clk;
	// A released bus shows the inverse of its last driven level
	assign busWire = busOe ? busOut : (devOe ? devOut : ~lastBus);
	always @(busWire or busOe or devOe) begin
		if (busOe === 1'b1 || devOe === 1'b1) lastBus = busWire;
	end
	nxh_host #(.NUM_CHIPS(2)) u_dut (.clk(clk), .nrst(nrst),
		.cmdValid(cmdValid), .cmd(cmd), .cmdReady(cmdReady),
		.rspDone(rspDone), .rspData(rspData),
		.transferStrobe(transferStrobe), .chipSelN(chipSelN),
		.nibbleBusIn(busWire), .nibbleBusOut(busOut),
		.nibbleBusOe(busOe));
	nxh_exp_model u_exp (.strobe(transferStrobe), .selN(chipSelN[0]),
		.bus(busWire), .extPin(extPin), .busOut(devOut), .busOe(devOe),
		.latch(latch), .portOe(portOe));
	////////////////////////////////////////
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp) begin
			n_fail++;
			$display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic complete_run();
		if (n_fail == 0 && compares > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	// One command; waits for the answer under a bound, checks latency
	task automatic run(input logic [1:0] op, input logic [1:0] chip,
		input logic [1:0] port, input logic [3:0] d, input int lat);
		int n;
		n = 0;
		while (cmdReady !== 1'b1 && n < 40) begin
			@(posedge clk);
			#1;
			n++;
		end
		cmd = {op, chip, port, d};
		cmdValid = 1'b1;
		@(posedge clk);
		#1;
		cmdValid = 1'b0;
		n = 0;
		do begin
			@(posedge clk);
			#1;
			n++;
		end while (rspDone !== 1'b1 && n < 60);
		chk(16'(n), 16'(lat));
	endtask
	////////////////////////////////////////
	// Direct writes to every port back to back, then OR and AND
	task automatic t_write();
		for (int p = 0; p < 4; p++) begin
			run(2'h1, 2'h0, 2'(p), 4'(p + 9), 13);
		end
		chk(latch, 16'hCBA9);
		chk(16'(portOe), 16'h000F);
		run(2'h2, 2'h0, 2'h1, 4'h5, 13);
		run(2'h3, 2'h0, 2'h2, 4'h6, 13);
		chk(latch, 16'hC2F9);
	endtask
	// Read after a write is repeated; the pins, not the latch, return
	task automatic t_read();
		extPin = 16'h3C5A;
		run(2'h0, 2'h0, 2'h0, 4'h0, 26);
		chk(16'(rspData), 16'h000A);
		chk(16'(portOe), 16'h000E);
		extPin = 16'h3C56;
		run(2'h0, 2'h0, 2'h0, 4'h0, 13);
		chk(16'(rspData), 16'h0006);
	endtask
	// A transfer for the other chip leaves this expander untouched
	task automatic t_select();
		run(2'h1, 2'h1, 2'h3, 4'h0, 13);
		chk(latch, 16'hC2F9);
		chk(16'(portOe), 16'h000E);
	endtask
	// Bus contention watch and hang limit, mid-cycle so both ends settled
	always @(negedge clk) begin
		cycles++;
		if (busOe === 1'b1 && devOe === 1'b1) chk(16'h0001, 16'h0000);
		if (cycles == 1500) begin
			n_fail++;
			complete_run();
		end
	end
	// Main sequence
	initial begin
		repeat (3) @(posedge clk);
		chk(16'({transferStrobe, chipSelN, busOe, portOe}), 16'h00E0);
		#1;
		nrst = 1'b1;
		t_write();
		t_read();
		t_select();
		complete_run();
	end
endmodule
